// ==== rtl/gated_phase_averager_pkg.sv ====
package gated_phase_averager_pkg;
	localparam int UNITS = 2;
	localparam int SAMPLE_W = 16;
	localparam int PHASE_W = 16;
	localparam int SUM_W = 32;
	localparam int TOTAL_W = 48;
	localparam int MA_DEPTH = 512;
	localparam int MA_PTR_W = 9;
	localparam int MA_LOG2_W = 4;
	localparam logic [3:0] MA_LOG2_MAX = 4'ha;
	localparam int BINS = 1024;
	localparam int BIN_W = 10;
	localparam int BIN_SUM_W = 40;
	localparam int BIN_CNT_W = 24;
	localparam int ZOOM_W = 3;
	localparam int SHOT_W = 48;
	// Input and analyzer rates in kSa/s; the resampler divides one by the other
	localparam int IN_RATE_KSPS = 1800000;
	localparam int PWA_RATE_KSPS = 450000;
	localparam int RESAMPLE_DIV = IN_RATE_KSPS / PWA_RATE_KSPS;
	localparam int RS_CNT_W = 2;
	localparam logic [BIN_W-1:0] BIN_LAST = 10'h03ff;
	localparam logic [BIN_CNT_W-1:0] BIN_CNT_MAX = 24'hff_ffff;
	typedef enum logic [1:0] {PWA_CLEAR, PWA_ACQ, PWA_DUMP} pwa_state_t;
endpackage

// ==== rtl/gated_phase_averager.sv ====
`timescale 1ns/1ns
`default_nettype none
module gated_phase_averager (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [1:0][gated_phase_averager_pkg::SAMPLE_W-1:0] in_data,
	input wire logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] int_osc_phase,
	input wire logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] ext_ref_phase,
	input wire logic [1:0] box_in_sel,
	input wire logic [1:0] box_osc_sel,
	input wire logic [1:0] box_ref_ext,
	input wire logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] gate_start,
	input wire logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] gate_width,
	input wire logic [1:0][gated_phase_averager_pkg::MA_LOG2_W-1:0] avg_log2,
	input wire logic [1:0] pwa_interlock,
	input wire logic [1:0] pwa_in_sel,
	input wire logic [1:0] pwa_osc_sel,
	input wire logic [1:0] pwa_ref_ext,
	input wire logic [1:0][gated_phase_averager_pkg::ZOOM_W-1:0] pwa_zoom_log2,
	input wire logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] pwa_zoom_start,
	input wire logic [1:0][gated_phase_averager_pkg::SHOT_W-1:0] pwa_shot_len,
	output logic [1:0][gated_phase_averager_pkg::SUM_W-1:0] sync_sum,
	output logic [1:0] sync_valid,
	output logic [1:0][gated_phase_averager_pkg::SUM_W-1:0] avg_out,
	output logic [1:0] avg_valid,
	output logic [1:0] bin_valid,
	output logic [1:0][gated_phase_averager_pkg::BIN_W-1:0] bin_index,
	output logic [1:0][gated_phase_averager_pkg::BIN_SUM_W-1:0] bin_sum,
	output logic [1:0][gated_phase_averager_pkg::BIN_CNT_W-1:0] bin_count,
	output logic [1:0] pwa_overflow
);
	////////////////////////////////////////////////////////////////////////////////
	// Phase helpers
	// Offset from a start phase, wrapping modulo one full turn
	function automatic logic [gated_phase_averager_pkg::PHASE_W-1:0] phase_off(
		input logic [gated_phase_averager_pkg::PHASE_W-1:0] ph,
		input logic [gated_phase_averager_pkg::PHASE_W-1:0] start);
		phase_off = ph - start;
	endfunction

	// Reference pick: oscillator index, then internal or external source
	function automatic logic [gated_phase_averager_pkg::PHASE_W-1:0] pick_ref(
		input logic osc,
		input logic ext,
		input logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] int_ph,
		input logic [1:0][gated_phase_averager_pkg::PHASE_W-1:0] ext_ph);
		pick_ref = ext ? ext_ph[osc] : int_ph[osc];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Two independent units
	genvar u;
	generate
		for (u = 0; u < gated_phase_averager_pkg::UNITS; u++) begin : g_unit
			logic [gated_phase_averager_pkg::SAMPLE_W-1:0] box_smp;
			logic [gated_phase_averager_pkg::PHASE_W-1:0] box_ph;
			logic [gated_phase_averager_pkg::PHASE_W-1:0] prev_ph_reg;
			logic [gated_phase_averager_pkg::SUM_W-1:0] acc_reg;
			logic [gated_phase_averager_pkg::SUM_W-1:0] acc_add;
			logic in_gate;
			logic wrap;
			logic [gated_phase_averager_pkg::SUM_W-1:0] sync_sum_reg;
			logic sync_valid_reg;

			assign box_smp = in_data[box_in_sel[u]];
			assign box_ph = pick_ref(box_osc_sel[u], box_ref_ext[u], int_osc_phase,
				ext_ref_phase);
			// Width is exclusive, so a full turn cannot be opened; one code short of it can
			assign in_gate = phase_off(box_ph, gate_start[u]) < gate_width[u];
			// A drop in phase marks the period boundary; needs reference below half the rate
			assign wrap = box_ph < prev_ph_reg;
			assign acc_add = in_gate ?
				gated_phase_averager_pkg::SUM_W'(signed'(box_smp)) : '0;

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					prev_ph_reg <= '0;
					acc_reg <= '0;
					sync_sum_reg <= '0;
					sync_valid_reg <= 1'b0;
				end else if (ce) begin
					sync_valid_reg <= 1'b0;
					if (in_valid) begin
						prev_ph_reg <= box_ph;
						if (wrap) begin
							// Hand on and restart in the same cycle, so no period is lost
							sync_sum_reg <= acc_reg;
							sync_valid_reg <= 1'b1;
							acc_reg <= acc_add;
						end else begin
							acc_reg <= acc_reg + acc_add;
						end
					end
				end
			end

			assign sync_sum[u] = sync_sum_reg;
			assign sync_valid[u] = sync_valid_reg;

			////////////////////////////////////////////////////////////////////////
			// Moving average over 2^avg_log2 periods, with avg_log2 capped at 10
			// Lengths are powers of two so the mean is a shift; lengthening it mid-run
			// gives a transient until the window refills, shortening it a lasting offset
			logic [gated_phase_averager_pkg::SUM_W:0] ma_mem [gated_phase_averager_pkg::MA_DEPTH];
			logic [gated_phase_averager_pkg::MA_LOG2_W-1:0] len_log2;
			logic pair_mode;
			logic [gated_phase_averager_pkg::MA_PTR_W:0] depth;
			logic [gated_phase_averager_pkg::MA_PTR_W-1:0] wp_reg;
			logic [gated_phase_averager_pkg::MA_PTR_W:0] fill_reg;
			logic half_reg;
			logic [gated_phase_averager_pkg::SUM_W-1:0] pair_reg;
			logic [gated_phase_averager_pkg::SUM_W:0] entry;
			logic push;
			logic [gated_phase_averager_pkg::SUM_W:0] oldest;
			logic [gated_phase_averager_pkg::TOTAL_W-1:0] total_reg;
			logic [gated_phase_averager_pkg::TOTAL_W-1:0] total_next;
			logic [gated_phase_averager_pkg::SUM_W-1:0] avg_reg;
			logic avg_valid_reg;

			assign len_log2 = (avg_log2[u] > gated_phase_averager_pkg::MA_LOG2_MAX) ?
				gated_phase_averager_pkg::MA_LOG2_MAX : avg_log2[u];
			// 1024 periods do not fit 512 slots: pairs of periods share one slot
			assign pair_mode = len_log2 == gated_phase_averager_pkg::MA_LOG2_MAX;
			assign depth = pair_mode ? 10'(gated_phase_averager_pkg::MA_DEPTH) :
				10'(1) << len_log2;
			assign push = sync_valid_reg && (!pair_mode || half_reg);
			assign entry = pair_mode ?
				(gated_phase_averager_pkg::SUM_W+1)'(signed'(pair_reg)) +
				(gated_phase_averager_pkg::SUM_W+1)'(signed'(sync_sum_reg)) :
				(gated_phase_averager_pkg::SUM_W+1)'(signed'(sync_sum_reg));
			assign oldest = ma_mem[wp_reg - depth[gated_phase_averager_pkg::MA_PTR_W-1:0]];
			always_comb begin
				total_next = total_reg + gated_phase_averager_pkg::TOTAL_W'(signed'(entry));
				if (fill_reg >= depth) begin
					total_next = total_next -
						gated_phase_averager_pkg::TOTAL_W'(signed'(oldest));
				end
			end

			always_ff @(posedge sys_clk) begin
				if (ce && push) begin
					ma_mem[wp_reg] <= entry;
				end
			end

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					wp_reg <= '0;
					fill_reg <= '0;
					half_reg <= 1'b0;
					pair_reg <= '0;
					total_reg <= '0;
					avg_reg <= '0;
					avg_valid_reg <= 1'b0;
				end else if (ce) begin
					avg_valid_reg <= 1'b0;
					if (sync_valid_reg && pair_mode) begin
						half_reg <= !half_reg;
						pair_reg <= sync_sum_reg;
					end
					if (push) begin
						wp_reg <= wp_reg + 1'b1;
						if (fill_reg < depth) begin
							fill_reg <= fill_reg + 1'b1;
						end
						total_reg <= total_next;
						avg_reg <= gated_phase_averager_pkg::SUM_W'(
							signed'(total_next) >>> len_log2);
						avg_valid_reg <= 1'b1;
					end
				end
			end

			assign avg_out[u] = avg_reg;
			assign avg_valid[u] = avg_valid_reg;

			////////////////////////////////////////////////////////////////////////
			// Phase-binned waveform analyzer
			logic [gated_phase_averager_pkg::BIN_SUM_W-1:0] bsum_mem [gated_phase_averager_pkg::BINS];
			logic [gated_phase_averager_pkg::BIN_CNT_W-1:0] bcnt_mem [gated_phase_averager_pkg::BINS];
			gated_phase_averager_pkg::pwa_state_t st_reg;
			logic a_in;
			logic a_osc;
			logic a_ext;
			logic [gated_phase_averager_pkg::SAMPLE_W-1:0] hold_reg;
			logic [gated_phase_averager_pkg::RS_CNT_W-1:0] rs_reg;
			logic tick;
			logic [gated_phase_averager_pkg::PHASE_W-1:0] a_ph;
			logic [gated_phase_averager_pkg::PHASE_W-1:0] z_off;
			logic in_span;
			logic [gated_phase_averager_pkg::BIN_W-1:0] idx;
			logic [gated_phase_averager_pkg::BIN_W-1:0] walk_reg;
			logic [gated_phase_averager_pkg::BIN_SUM_W-1:0] cur_sum;
			logic [gated_phase_averager_pkg::BIN_SUM_W-1:0] new_sum;
			logic [gated_phase_averager_pkg::BIN_CNT_W-1:0] cur_cnt;
			logic sum_ovf;
			logic cnt_ovf;
			logic [gated_phase_averager_pkg::SHOT_W-1:0] taken_reg;
			logic [gated_phase_averager_pkg::SHOT_W-1:0] shot_end;
			logic ovf_acc_reg;
			logic [gated_phase_averager_pkg::BIN_W-1:0] bidx_reg;
			logic [gated_phase_averager_pkg::BIN_SUM_W-1:0] bsum_reg;
			logic [gated_phase_averager_pkg::BIN_CNT_W-1:0] bcnt_reg;
			logic bvalid_reg;
			logic povf_reg;

			assign a_in = pwa_interlock[u] ? box_in_sel[u] : pwa_in_sel[u];
			assign a_osc = pwa_interlock[u] ? box_osc_sel[u] : pwa_osc_sel[u];
			assign a_ext = pwa_interlock[u] ? box_ref_ext[u] : pwa_ref_ext[u];
			assign a_ph = pick_ref(a_osc, a_ext, int_osc_phase, ext_ref_phase);
			// Fixed-rate pick of the latest value: repeats when slow, skips when fast
			assign tick = rs_reg == gated_phase_averager_pkg::RS_CNT_W'(
				gated_phase_averager_pkg::RESAMPLE_DIV - 1);
			// Zoom span is a full turn shifted down by the zoom setting
			assign z_off = phase_off(a_ph, pwa_zoom_start[u]);
			assign in_span = (z_off >> (gated_phase_averager_pkg::PHASE_W -
				32'(pwa_zoom_log2[u]))) == '0 || pwa_zoom_log2[u] == '0;
			assign idx = gated_phase_averager_pkg::BIN_W'(z_off >>
				(gated_phase_averager_pkg::PHASE_W - gated_phase_averager_pkg::BIN_W -
				32'(pwa_zoom_log2[u])));
			assign cur_sum = bsum_mem[idx];
			assign cur_cnt = bcnt_mem[idx];
			assign new_sum = cur_sum + gated_phase_averager_pkg::BIN_SUM_W'(signed'(hold_reg));
			assign sum_ovf = (cur_sum[gated_phase_averager_pkg::BIN_SUM_W-1] ==
				hold_reg[gated_phase_averager_pkg::SAMPLE_W-1]) &&
				(new_sum[gated_phase_averager_pkg::BIN_SUM_W-1] !=
				cur_sum[gated_phase_averager_pkg::BIN_SUM_W-1]);
			assign cnt_ovf = cur_cnt == gated_phase_averager_pkg::BIN_CNT_MAX;
			// Zero is read as one so a shot always holds at least one sample
			assign shot_end = (pwa_shot_len[u] == '0) ? gated_phase_averager_pkg::SHOT_W'(1) :
				pwa_shot_len[u];

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					hold_reg <= '0;
					rs_reg <= '0;
				end else if (ce) begin
					if (in_valid) begin
						hold_reg <= in_data[a_in];
					end
					rs_reg <= tick ? '0 : rs_reg + 1'b1;
				end
			end

			// Bins clear after reset and during each dump; no reset on the arrays
			always_ff @(posedge sys_clk) begin
				if (ce) begin
					if (st_reg != gated_phase_averager_pkg::PWA_ACQ) begin
						bsum_mem[walk_reg] <= '0;
						bcnt_mem[walk_reg] <= '0;
					end else if (tick && in_span) begin
						// Keep the bin's old value rather than wrap, so a bad bin stays recognisable
						bsum_mem[idx] <= sum_ovf ? cur_sum : new_sum;
						bcnt_mem[idx] <= cnt_ovf ? cur_cnt : cur_cnt + 1'b1;
					end
				end
			end

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					st_reg <= gated_phase_averager_pkg::PWA_CLEAR;
					walk_reg <= '0;
					taken_reg <= '0;
					ovf_acc_reg <= 1'b0;
					povf_reg <= 1'b0;
				end else if (ce) begin
					unique case (st_reg)
						gated_phase_averager_pkg::PWA_CLEAR, gated_phase_averager_pkg::PWA_DUMP: begin
							walk_reg <= walk_reg + 1'b1;
							if (walk_reg == gated_phase_averager_pkg::BIN_LAST) begin
								st_reg <= gated_phase_averager_pkg::PWA_ACQ;
								taken_reg <= '0;
							end
						end
						gated_phase_averager_pkg::PWA_ACQ: begin
							if (tick) begin
								// Samples during a dump are not counted toward the next shot
								taken_reg <= taken_reg + 1'b1;
								if (in_span && (sum_ovf || cnt_ovf)) begin
									ovf_acc_reg <= 1'b1;
								end
								if (taken_reg + 1'b1 == shot_end) begin
									st_reg <= gated_phase_averager_pkg::PWA_DUMP;
									walk_reg <= '0;
									povf_reg <= ovf_acc_reg || (in_span && (sum_ovf || cnt_ovf));
									ovf_acc_reg <= 1'b0;
								end
							end
						end
					endcase
				end
			end

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					bidx_reg <= '0;
					bsum_reg <= '0;
					bcnt_reg <= '0;
					bvalid_reg <= 1'b0;
				end else if (ce) begin
					bvalid_reg <= st_reg == gated_phase_averager_pkg::PWA_DUMP;
					bidx_reg <= walk_reg;
					bsum_reg <= bsum_mem[walk_reg];
					bcnt_reg <= bcnt_mem[walk_reg];
				end
			end

			assign bin_valid[u] = bvalid_reg;
			assign bin_index[u] = bidx_reg;
			assign bin_sum[u] = bsum_reg;
			assign bin_count[u] = bcnt_reg;
			assign pwa_overflow[u] = povf_reg;
		end
	endgenerate
endmodule // gated_phase_averager
`default_nettype wire

// ==== verif/gated_phase_averager_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module gated_phase_averager_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [1:0][31:0] sync_sum,
	input wire logic [1:0] sync_valid,
	input wire logic [1:0] avg_valid,
	input wire logic [1:0] bin_valid,
	input wire logic [1:0][9:0] bin_index
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	// Phase steps stay under half a turn, so two wraps in a row cannot happen
	sync_pulse_a: assert property (sync_valid[0] && ce |=> !sync_valid[0])
		else $error("sync pulse longer than one cycle");
	unit_two_a: assert property (sync_valid[1] && ce |=> !sync_valid[1])
		else $error("second unit sync pulse too long");
	sync_cause_a: assert property ($rose(sync_valid[0]) |-> $past(in_valid && ce))
		else $error("period sum without a taken sample");
	avg_follow_a: assert property ($rose(avg_valid[0]) |-> $past(sync_valid[0]))
		else $error("average not one cycle after sum");
	sum_hold_a: assert property (!sync_valid[0] |-> $stable(sync_sum[0]))
		else $error("sum changed without a pulse");
	dump_start_a: assert property ($rose(bin_valid[0]) |-> bin_index[0] == 10'h000)
		else $error("dump does not start at bin zero");
	bin_step_a: assert property (bin_valid[0] && ce && bin_index[0] != 10'h3ff
		|=> bin_valid[0] && bin_index[0] == $past(bin_index[0]) + 10'h001)
		else $error("bin index did not step by one");
	dump_end_a: assert property (bin_valid[0] && ce && bin_index[0] == 10'h3ff |=> !bin_valid[0])
		else $error("dump longer than the bin count");
	ce_freeze_a: assert property (!ce |=> $stable(sync_valid) && $stable(sync_sum)
		&& $stable(bin_index))
		else $error("state moved while disabled");
	cover property ($rose(avg_valid[1]));
	cover property ($rose(bin_valid[0]));
	cover property (!ce && sync_valid[0]);
endmodule // gated_phase_averager_assertions
bind gated_phase_averager gated_phase_averager_assertions u_chk (.sys_clk, .nrst, .ce, .in_valid,
	.sync_sum, .sync_valid, .avg_valid, .bin_valid, .bin_index);
`default_nettype wire

// ==== verif/ref_stream_source.sv ====
`timescale 1ns/1ns
`default_nettype none
module ref_stream_source (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [15:0] step,
	output logic in_valid,
	output logic [1:0][15:0] in_data,
	output logic [1:0][15:0] int_osc_phase,
	output logic [1:0][15:0] ext_ref_phase
);
	// Data changes every cycle, so a stale sample never passes for a fresh one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			in_valid <= 1'h0;
			in_data <= '0;
		end else begin
			in_valid <= ($urandom % 8) != 0;
			in_data <= {16'($urandom), 16'($urandom)};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Phases move only on taken samples; steps stay under half a turn
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			int_osc_phase <= '0;
			ext_ref_phase <= {16'h4000, 16'h9000};
		end else if (in_valid && ce) begin
			int_osc_phase[0] <= int_osc_phase[0] + step;
			int_osc_phase[1] <= int_osc_phase[1] + 16'(step * 3);
			ext_ref_phase[0] <= ext_ref_phase[0] + 16'(step + 7);
			ext_ref_phase[1] <= ext_ref_phase[1] + 16'(step * 2);
		end
	end
endmodule // ref_stream_source
`default_nettype wire

// ==== verif/test_gated_phase_averager.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_gated_phase_averager;
	logic sys_clk, in_valid;
	logic nrst = 1'h0, ce = 1'h0;
	logic [15:0] step = '0;
	logic [1:0][15:0] in_data, int_osc_phase, ext_ref_phase;
	logic [1:0][15:0] gate_start = '0, gate_width = '0, pwa_zoom_start = '0;
	logic [1:0] box_in_sel = '0, box_osc_sel = '0, box_ref_ext = '0, pwa_interlock = '0;
	logic [1:0] pwa_in_sel = '0, pwa_osc_sel = '0, pwa_ref_ext = '0;
	logic [1:0][3:0] avg_log2 = '0;
	logic [1:0][2:0] pwa_zoom_log2 = '0;
	logic [1:0][47:0] pwa_shot_len = '0;
	logic [1:0][31:0] sync_sum, avg_out;
	logic [1:0] sync_valid, avg_valid, bin_valid, pwa_overflow;
	logic [1:0][9:0] bin_index;
	logic [1:0][39:0] bin_sum;
	logic [1:0][23:0] bin_count;
	logic [15:0] prev[2], p;
	int mismatches = 0, checks = 0, dpos[2], n[2], l;
	longint sq[2][$], aq[2][$], hist[2][$], acc[2], csum[2], e, s;

	gated_phase_averager u_dut (.sys_clk, .nrst, .ce, .in_valid, .in_data, .int_osc_phase,
		.ext_ref_phase, .box_in_sel, .box_osc_sel, .box_ref_ext, .gate_start, .gate_width,
		.avg_log2, .pwa_interlock, .pwa_in_sel, .pwa_osc_sel, .pwa_ref_ext, .pwa_zoom_log2,
		.pwa_zoom_start, .pwa_shot_len, .sync_sum, .sync_valid, .avg_out, .avg_valid,
		.bin_valid, .bin_index, .bin_sum, .bin_count, .pwa_overflow);
	ref_stream_source u_src (.sys_clk, .nrst, .ce, .step, .in_valid, .in_data, .int_osc_phase,
		.ext_ref_phase);

	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task end_of_test;
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Settings change only under reset: a live lengthening gives transients, a shortening a lasting offset
	task setup(input logic [3:0] l0, input logic [3:0] l1, input logic [47:0] len0);
		@(posedge sys_clk);
		nrst <= 1'h0;
		step <= 16'h0800 + 16'($urandom % 16'h1800);
		gate_start <= {16'($urandom), 16'($urandom)};
		gate_width <= {16'($urandom), 16'($urandom)};
		{box_in_sel, box_osc_sel, box_ref_ext} <= 6'($urandom);
		{pwa_interlock, pwa_in_sel, pwa_osc_sel, pwa_ref_ext} <= 8'($urandom);
		avg_log2 <= {l1, l0};
		pwa_zoom_log2 <= {3'(1 + $urandom % 6), 3'h0};
		pwa_zoom_start <= {16'($urandom), 16'h0000};
		pwa_shot_len <= {48'(1 + $urandom % 400), len0};
		repeat (11) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (6000) begin
			@(posedge sys_clk);
			ce <= ($urandom % 16) != 0;
		end
	endtask

	initial begin
		void'($urandom(94));
		setup(4'h2, 4'hf, 48'h0000_0000_0064);
		setup(4'ha, 4'h0, 48'h0000_0000_0000);
		end_of_test;
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Reference model of both units, checked at every result
	always @(posedge sys_clk) begin
		for (int u = 0; u < 2; u++) begin
			if (!nrst) begin
				sq[u] = {};
				aq[u] = {};
				hist[u] = {};
				acc[u] = 0;
				prev[u] = '0;
				dpos[u] = 0;
				csum[u] = 0;
				n[u] = 0;
			end else begin
				if (sync_valid[u] && ce) begin
					e = sq[u].size() ? sq[u].pop_front() : -1;
					chk(sync_sum[u] === 32'(e), "period sum");
				end
				if (avg_valid[u] && ce) begin
					e = aq[u].size() ? aq[u].pop_front() : -1;
					chk(avg_out[u] === 32'(e), "moving average");
				end
				if (bin_valid[u] && ce) begin
					chk(bin_index[u] === 10'(dpos[u]), "bin order");
					chk(bin_count[u] !== '0 || bin_sum[u] === '0, "empty bin sum");
					csum[u] += bin_count[u];
					dpos[u]++;
					if (dpos[u] == 1024) begin
						e = pwa_shot_len[u] ? pwa_shot_len[u] : 1;
						chk(u ? csum[u] <= e : csum[u] == e, "bin counts");
						chk(pwa_overflow[u] === 1'h0, "overflow flag");
						dpos[u] = 0;
						csum[u] = 0;
					end
				end
				if (ce && in_valid) begin
					p = box_ref_ext[u] ? ext_ref_phase[box_osc_sel[u]] : int_osc_phase[box_osc_sel[u]];
					if (p < prev[u]) begin
						sq[u].push_back(acc[u]);
						hist[u].push_back(acc[u]);
						if (hist[u].size() > 1024) void'(hist[u].pop_front());
						n[u]++;
						l = avg_log2[u] > 10 ? 10 : avg_log2[u];
						s = 0;
						for (int k = 0; k < (1 << l) && k < hist[u].size(); k++) begin
							s += hist[u][hist[u].size() - 1 - k];
						end
						if (l < 10 || n[u] % 2 == 0) aq[u].push_back(s >>> l);
						acc[u] = 0;
					end
					if (16'(p - gate_start[u]) < gate_width[u]) begin
						acc[u] += $signed(in_data[box_in_sel[u]]);
					end
					prev[u] = p;
				end
			end
		end
	end
endmodule // test_gated_phase_averager
`default_nettype wire
